// ==== temp_conv_pkg.sv ====
`default_nettype none
package temp_conv_pkg;
   // ---------------------------------------------------------------
   // clock and conversion timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_HZ          = 50_000_000;
   localparam int unsigned CONV_TIME_MS_9  = 150;
   localparam int unsigned CONV_TIME_MS_10 = 300;
   localparam int unsigned CONV_TIME_MS_11 = 600;
   localparam int unsigned CONV_TIME_MS_12 = 1200;
   // shortest time: round down to whole cycles
   localparam int unsigned CONV_CYCLES_9   = CONV_TIME_MS_9 * (CLK_HZ / 1000);
   localparam int unsigned CNT_W           = 27;

   // ---------------------------------------------------------------
   // configuration byte layout
   // ---------------------------------------------------------------
   localparam int unsigned CFG_RSVD_BIT    = 7;
   localparam int unsigned CFG_RES_HI      = 6;
   localparam int unsigned CFG_RES_LO      = 5;
   localparam int unsigned CFG_FAULT_HI    = 4;
   localparam int unsigned CFG_FAULT_LO    = 3;
   localparam int unsigned CFG_POL_BIT     = 2;
   localparam int unsigned CFG_TM_BIT      = 1;
   localparam int unsigned CFG_SD_BIT      = 0;
   localparam logic [7:0]  CFG_RESET       = 8'h00;
   localparam logic [7:0]  CFG_WR_MASK     = 8'h7F;

   // ---------------------------------------------------------------
   // temperature word
   // ---------------------------------------------------------------
   localparam logic [15:0] TEMP_RESET      = 16'h0000;
   localparam logic [15:0] MASK_9BIT       = 16'hFF80;
   localparam logic [3:0]  TEMP_LOW_ZERO   = 4'h0;
   localparam logic [1:0]  RES_9BIT        = 2'h0;
   localparam logic [1:0]  RES_12BIT       = 2'h3;

   typedef enum logic {st_convert, st_standby} conv_state_e;

   // keeps the top bits that carry data at the given resolution
   function automatic logic [15:0] res_mask(input logic [1:0] res);
      logic signed [15:0] m;
      m = $signed(MASK_9BIT);
      return 16'(m >>> res);
   endfunction : res_mask
endpackage : temp_conv_pkg
`default_nettype wire

// ==== temp_conversion_result_shutdown.sv ====
// Function
// - conversion ends within 150, 300, 600 or 1200 ms by resolution.
// - conversions start by themselves straight after power-up reset.
// - resolution 9 to 12 bits selectable, 9 bits after power-up.
// - active resolution comes from the two resolution select bits.
// - each completed conversion stores a 16-bit two's complement word.
// - bit 15 is the sign, one for negative temperatures.
// - bits 14 to 4 weigh 2^6 down to 2^-4 degrees.
// - bits 3 to 0 of the word always read zero.
// - only the top N bits hold data at N-bit resolution.
// - a read returns the most recently completed result.
// - reads never abort, restart or disturb a running conversion.
// - shutdown set finishes and stores the running conversion, then idles.
// - entering shutdown in interrupt mode clears the alarm.
// - entering shutdown in comparator mode leaves the alarm as it is.
// - register access keeps working during shutdown.
// - writing shutdown back to zero resumes normal conversion.
// - shutdown bit resets to zero; zero converts, one shuts down.
// - interrupt mode alarm holds until shutdown entry or a register read.
`timescale 1ns/1ps
`default_nettype none
module temp_conversion_result_shutdown #(
   parameter int unsigned CONV_CYCLES_9 = temp_conv_pkg::CONV_CYCLES_9
) (
   input  wire logic        clk,           // 50 MHz clock
   input  wire logic        srst,          // sync reset, active high
   input  wire logic        cfg_wr,        // config write strobe
   input  wire logic [7:0]  cfg_wdata,     // config write byte
   input  wire logic        reg_rd,        // any register read strobe
   input  wire logic [11:0] sensor_code,   // converter output, 1/16 C
   input  wire logic        trip_set,      // thermostat activate event
   input  wire logic        trip_clr,      // comparator release event
   output logic [7:0]       cfg_rdata,     // config register contents
   output logic [15:0]      temp_rdata,    // temperature register
   output logic             conv_done,     // result stored pulse
   output logic             standby,       // low-power idle state
   output logic             alarm_active   // thermostat alarm, logical
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   temp_conv_pkg::conv_state_e               state;
   temp_conv_pkg::conv_state_e               next_state;
   logic [temp_conv_pkg::CNT_W-1:0]          cnt;
   logic [temp_conv_pkg::CNT_W-1:0]          next_cnt;
   logic [1:0]                               res_run;
   logic [1:0]                               next_res_run;
   logic [15:0]                              next_temp;
   logic [7:0]                               next_cfg;
   logic                                     next_done;
   logic                                     next_standby;
   logic                                     next_alarm;
   logic [temp_conv_pkg::CNT_W-1:0]          limit;
   logic                                     last_cycle;
   logic                                     enter_sd;
   logic                                     start_conv;
   logic                                     sd_bit;
   logic                                     tm_bit;

   localparam logic [temp_conv_pkg::CNT_W-1:0] LIM_9 =
      temp_conv_pkg::CNT_W'(CONV_CYCLES_9);

   assign sd_bit     = cfg_rdata[temp_conv_pkg::CFG_SD_BIT];
   assign tm_bit     = cfg_rdata[temp_conv_pkg::CFG_TM_BIT];
   // conversion time doubles per added bit
   assign limit      = LIM_9 << res_run;
   assign last_cycle = (state == temp_conv_pkg::st_convert) &&
                       (cnt == limit - 1'b1);
   assign enter_sd   = last_cycle && sd_bit;
   assign start_conv = (last_cycle && !sd_bit) ||
                       (state == temp_conv_pkg::st_standby && !sd_bit);

   // ---------------------------------------------------------------
   // config register
   // ---------------------------------------------------------------
   always_comb begin
      next_cfg = cfg_rdata;
      // writes accepted in any state; reserved bit reads zero
      if (cfg_wr) begin
         next_cfg = cfg_wdata & temp_conv_pkg::CFG_WR_MASK;
      end
   end

   // ---------------------------------------------------------------
   // conversion sequencer
   // ---------------------------------------------------------------
   always_comb begin
      next_state   = state;
      next_cnt     = cnt;
      next_res_run = res_run;
      next_temp    = temp_rdata;
      next_done    = 1'b0;
      next_standby = standby;
      case (state)
         temp_conv_pkg::st_convert: begin
            // reads do not touch this path
            if (last_cycle) begin
               next_temp = {sensor_code, temp_conv_pkg::TEMP_LOW_ZERO} &
                           temp_conv_pkg::res_mask(res_run);
               next_done = 1'b1;
               next_cnt  = '0;
               if (sd_bit) begin
                  next_state   = temp_conv_pkg::st_standby;
                  next_standby = 1'b1;
               end else begin
                  next_res_run = cfg_rdata[temp_conv_pkg::CFG_RES_HI:
                                           temp_conv_pkg::CFG_RES_LO];
               end
            end else begin
               next_cnt = cnt + 1'b1;
            end
         end
         temp_conv_pkg::st_standby: begin
            if (!sd_bit) begin
               next_state   = temp_conv_pkg::st_convert;
               next_standby = 1'b0;
               next_cnt     = '0;
               next_res_run = cfg_rdata[temp_conv_pkg::CFG_RES_HI:
                                        temp_conv_pkg::CFG_RES_LO];
            end
         end
         default: begin
            next_state   = temp_conv_pkg::st_convert;
            next_cnt     = '0;
            next_standby = 1'b0;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // alarm state
   // ---------------------------------------------------------------
   always_comb begin
      next_alarm = alarm_active;
      if (tm_bit) begin
         if (reg_rd) begin
            next_alarm = 1'b0;
         end
         if (trip_set && !standby) begin
            next_alarm = 1'b1;
         end
         if (enter_sd) begin
            next_alarm = 1'b0;
         end
      end else begin
         // shutdown entry is ignored here
         if (trip_clr) begin
            next_alarm = 1'b0;
         end
         if (trip_set && !standby) begin
            next_alarm = 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         state        <= temp_conv_pkg::st_convert;
         cnt          <= '0;
         res_run      <= temp_conv_pkg::RES_9BIT;
         cfg_rdata    <= temp_conv_pkg::CFG_RESET;
         temp_rdata   <= temp_conv_pkg::TEMP_RESET;
         conv_done    <= 1'b0;
         standby      <= 1'b0;
         alarm_active <= 1'b0;
      end else begin
         state        <= next_state;
         cnt          <= next_cnt;
         res_run      <= next_res_run;
         cfg_rdata    <= next_cfg;
         temp_rdata   <= next_temp;
         conv_done    <= next_done;
         standby      <= next_standby;
         alarm_active <= next_alarm;
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   a_conv_time_bound: assert property (
      (state == temp_conv_pkg::st_convert) |-> (cnt < limit))
      else $error("conversion ran past its maximum time");

   a_powerup_start: assert property (
      @(posedge clk) disable iff (1'b0)
      $past(srst) && !srst |->
         (state == temp_conv_pkg::st_convert) && (cnt == '0) && !standby)
      else $error("no conversion started after reset");

   a_powerup_res: assert property (
      @(posedge clk) disable iff (1'b0)
      $past(srst) |-> (res_run == temp_conv_pkg::RES_9BIT) &&
                      (cfg_rdata == temp_conv_pkg::CFG_RESET))
      else $error("reset did not select 9-bit and active mode");

   a_res_from_cfg: assert property (
      start_conv |=> res_run == $past(cfg_rdata[temp_conv_pkg::CFG_RES_HI:
                                         temp_conv_pkg::CFG_RES_LO]))
      else $error("conversion did not take configured resolution");

   a_store_value: assert property (
      conv_done |-> temp_rdata ==
         ({$past(sensor_code), temp_conv_pkg::TEMP_LOW_ZERO} &
          temp_conv_pkg::res_mask($past(res_run))))
      else $error("stored word differs from converter code");

   a_low_bits_zero: assert property (
      temp_rdata[3:0] == temp_conv_pkg::TEMP_LOW_ZERO)
      else $error("temperature bits 3..0 not zero");

   a_res_unused_zero: assert property (
      conv_done |->
         (temp_rdata & ~temp_conv_pkg::res_mask($past(res_run))) == 16'h0000)
      else $error("bits below resolution not zero");

   a_result_holds: assert property (
      !conv_done && !$past(srst) |-> $stable(temp_rdata))
      else $error("temperature changed without a conversion");

   a_read_no_restart: assert property (
      reg_rd && (state == temp_conv_pkg::st_convert) && !last_cycle |=>
         cnt == $past(cnt) + 1'b1)
      else $error("read disturbed the running conversion");

   a_shutdown_idle: assert property (
      enter_sd |=> conv_done && standby)
      else $error("shutdown did not store and idle");

   a_standby_quiet: assert property (
      standby && sd_bit |=> standby && !conv_done)
      else $error("conversion ran during shutdown");

   a_int_sd_clear: assert property (
      enter_sd && tm_bit |=> !alarm_active)
      else $error("interrupt alarm not cleared on shutdown");

   a_cmp_sd_keep: assert property (
      enter_sd && !tm_bit && !trip_set && !trip_clr |=> $stable(alarm_active))
      else $error("comparator alarm changed on shutdown");

   a_write_in_sd: assert property (
      cfg_wr |=> cfg_rdata == ($past(cfg_wdata) & temp_conv_pkg::CFG_WR_MASK))
      else $error("config write lost");

   a_wake_fresh: assert property (
      standby && !sd_bit |=> !standby && (cnt == '0) && $stable(temp_rdata))
      else $error("leaving shutdown did not start afresh");

   a_back_to_back: assert property (
      last_cycle && !sd_bit |=> (state == temp_conv_pkg::st_convert) &&
                                 (cnt == '0))
      else $error("next conversion did not follow");

   a_int_alarm_hold: assert property (
      tm_bit && alarm_active && !reg_rd && !enter_sd && !cfg_wr |=>
         alarm_active)
      else $error("interrupt alarm dropped early");

   c_conv_12bit: cover property (
      conv_done && $past(res_run) == temp_conv_pkg::RES_12BIT);
   c_enter_sd: cover property (enter_sd ##1 standby);
   c_wake: cover property (standby ##1 !standby ##[1:20] !standby);
   c_int_read_clear: cover property (tm_bit && alarm_active && reg_rd);
endmodule : temp_conversion_result_shutdown
`default_nettype wire

// ==== host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// host side of the register port
// ----------------------------------------
module host_model (
   input  wire logic       clk,       // bench clock
   output var  logic       cfg_wr,    // config write strobe
   output var  logic [7:0] cfg_wdata  // config write byte
);
   initial begin
      cfg_wr    = 1'b0;
      cfg_wdata = 8'h5A;
   end
   // one-cycle write, data scrambled once released
   task automatic write_cfg(input logic [7:0] v);
      @(posedge clk);
      cfg_wr    <= 1'b1;
      cfg_wdata <= v;
      @(posedge clk);
      cfg_wr    <= 1'b0;
      cfg_wdata <= ~v;
   endtask : write_cfg
endmodule : host_model
`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam int unsigned L9 = 8;
   logic        clk, srst, reg_rd, trip_set, trip_clr, cfg_wr;
   logic        conv_done, standby, alarm_active;
   logic [7:0]  cfg_wdata, cfg_rdata, m_cfg;
   logic [11:0] sensor_code;
   logic [15:0] temp_rdata, m_mask, m_exp, m_temp;
   logic [31:0] rng = 32'h0000_8FEF;
   logic [1:0]  m_res;
   logic        m_alarm, ent, m_rst;
   bit          m_run, m_wake, m_sdl;
   int          m_cnt, m_len, fail_count, tests_run;

   temp_conversion_result_shutdown #(.CONV_CYCLES_9(L9)) DUT (
      .clk(clk), .srst(srst), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
      .reg_rd(reg_rd), .sensor_code(sensor_code), .trip_set(trip_set),
      .trip_clr(trip_clr), .cfg_rdata(cfg_rdata),
      .temp_rdata(temp_rdata), .conv_done(conv_done),
      .standby(standby), .alarm_active(alarm_active));
   host_model host (.clk(clk), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata));

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [31:0] xorshift(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      x = x ^ (x << 5);
      return x;
   endfunction : xorshift

   task automatic chk_word(input string n, input logic [15:0] e,
                           input logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk_word

   task automatic chk_bit(input string n, input logic e, input logic g);
      tests_run++;
      if (g !== e) begin
         fail_count++;
         $display("ERROR %s expected %b seen %b", n, e, g);
      end
   endtask : chk_bit

   task automatic stop_test();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : stop_test

   task automatic end_test(input string n);
      $display("test %s done at %0t", n, $time);
   endtask : end_test

   task automatic wait_done(input int n);
      int k;
      k = 0;
      while (n > 0 && k < 300) begin
         @(negedge clk);
         k++;
         if (conv_done === 1'b1) n--;
      end
      if (n > 0) chk_bit("done wait", 1'b1, 1'b0);
   endtask : wait_done

   // ----------------------------------------
   // clock, random inputs, watchdog
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   always @(posedge clk) begin
      rng = xorshift(rng);
      sensor_code <= rng[11:0];
      trip_set    <= (rng[15:12] == 4'h0);
      trip_clr    <= (rng[19:16] == 4'h0);
      reg_rd      <= (rng[22:20] == 3'h0);
      // reset as the design sampled it at this edge
      m_rst       <= srst;
   end

   initial begin
      #400000;
      fail_count++;
      stop_test();
   end

   // ----------------------------------------
   // reference model, checked every cycle
   // ----------------------------------------
   always @(negedge clk) begin
      // the design was reset at the edge just gone: restart the model
      if (m_rst) begin
         {m_run, m_cnt, m_cfg, m_wake} = {1'b1, 32'd0, 8'h00, 1'b0};
         {m_temp, m_alarm, m_len, m_res} = {16'h0000, 1'b0, L9, 2'h0};
      end
      if (!m_run && m_wake) begin
         m_run = 1'b1;
         m_cnt = 0;
      end
      if (m_run && m_cnt == m_len) begin
         m_temp = m_exp;
         chk_bit("conv_done", 1'b1, conv_done);
         chk_bit("standby", m_sdl, standby);
         m_cnt = 0;
         m_run = !m_sdl;
      end else begin
         chk_bit("conv_done", 1'b0, conv_done);
         chk_bit("standby", !m_run, standby);
      end
      if (m_run && m_cnt == 0) begin
         m_len  = L9 << m_res;
         m_mask = 16'hFFFF << (7 - m_res);
      end
      ent = m_run && (m_cnt == m_len - 1) && m_cfg[0];
      if (m_run && m_cnt == m_len - 1) begin
         m_exp = {sensor_code, 4'h0} & m_mask;
         m_sdl = m_cfg[0];
      end
      if (m_run) m_cnt++;
      chk_word("temp_rdata", m_temp, temp_rdata);
      chk_word("cfg_rdata", {8'h00, m_cfg}, {8'h00, cfg_rdata});
      chk_bit("alarm_active", m_alarm, alarm_active);
      if (m_cfg[1]) begin
         if (ent) m_alarm = 1'b0;
         else if (trip_set && m_run) m_alarm = 1'b1;
         else if (reg_rd) m_alarm = 1'b0;
      end else begin
         if (trip_set && m_run) m_alarm = 1'b1;
         else if (trip_clr) m_alarm = 1'b0;
      end
      m_wake = !m_run && !m_cfg[0];
      // resolution that a conversion starting at the next edge takes
      m_res  = m_cfg[6:5];
      if (cfg_wr) m_cfg = cfg_wdata & 8'h7F;
   end

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      srst = 1'b1;
      fail_count = 0;
      tests_run = 0;
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      wait_done(3);
      end_test("power-up");
      for (int r = 1; r < 4; r++) begin
         host.write_cfg({1'b1, r[1:0], 5'h00});
         wait_done(2);
      end
      end_test("resolution");
      host.write_cfg(8'h03);
      wait_done(1);
      repeat (40) @(negedge clk);
      host.write_cfg(8'h23);
      repeat (10) @(negedge clk);
      host.write_cfg(8'h20);
      wait_done(2);
      end_test("interrupt shutdown");
      host.write_cfg(8'h01);
      wait_done(1);
      repeat (30) @(negedge clk);
      host.write_cfg(8'h00);
      wait_done(1);
      end_test("comparator shutdown");
      @(posedge clk);
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      wait_done(2);
      end_test("second reset");
      stop_test();
   end
endmodule : tb
`default_nettype wire
